// >>> hw/pwt_defs.vh
// Register map, field positions and codes for the configurable PWM timer.
// Assumes a 32-bit APB slave with byte addresses decoded on paddr[7:0].
`ifndef PWT_DEFS_VH
`define PWT_DEFS_VH

// Register byte offsets, one aligned word each
`define PWT_CTRL        8'h00
`define PWT_STATUS      8'h04
`define PWT_IRQ_MASK    8'h08
`define PWT_DMA_MASK    8'h0c
`define PWT_COUNT       8'h10
`define PWT_PRESC       8'h14
`define PWT_RELOAD      8'h18
`define PWT_DEADTIME    8'h1c
`define PWT_CCMODE      8'h20
`define PWT_OUT_EN      8'h24
`define PWT_CCR0        8'h30
`define PWT_CCR_LAST    8'h3c

// Control register fields
`define PWT_CTRL_EN     0
`define PWT_CTRL_DIR_LO 1
`define PWT_CTRL_DIR_HI 2
`define PWT_CTRL_OPM    3
`define PWT_CTRL_FRZ    4
`define PWT_CTRL_DOFF   5
`define PWT_CTRL_MOE    6
`define PWT_CTRL_SLV_LO 8
`define PWT_CTRL_SLV_HI 9
`define PWT_CTRL_ENC    10
`define PWT_CTRL_W      11

// Counting directions
`define PWT_DIR_UP      2'h0
`define PWT_DIR_DOWN    2'h1
`define PWT_DIR_CENTER  2'h2

// Link (slave) modes
`define PWT_SLV_NONE    2'h0
`define PWT_SLV_RESET   2'h1
`define PWT_SLV_GATED   2'h2
`define PWT_SLV_EXTCLK  2'h3

// Channel modes, four bits per channel in the mode register
`define PWT_CC_FROZEN   2'h0
`define PWT_CC_CAPTURE  2'h1
`define PWT_CC_TOGGLE   2'h2
`define PWT_CC_PWM      2'h3

// Status bits: update in bit 0, channel i in bit i+1
`define PWT_ST_UPD      0
`define PWT_ST_W        5

// Reset values
`define PWT_RELOAD_RST  16'hffff

`endif

// >>> hw/pwt_timer.v
// Configurable 16-bit timer: counter, prescaler, up to four capture/compare
// channels, complementary outputs with dead-time, timer link, IRQ and DMA.
// Assumes an APB master on pclk; all pin and link inputs are synchronous.
//
// Summary of operation
// R01: Four-channel variant counts up, down or up/down behind 16-bit prescaler.
// R02: Each of four channels does capture, compare, edge/center PWM or one-pulse.
// R03: PWM duty covers 0% (compare zero) through 100% (compare above reload).
// R04: Up to three complementary pairs with programmable dead-time at each edge.
// R05: Debug halt can freeze the counter and force outputs inactive.
// R06: Link input resets, gates or clocks counter; update drives link output.
// R07: Up/down variant raises DMA requests and counts quadrature encoder pairs.
// R08: Single-channel variant: 16-bit up-only counter, 16-bit prescaler, one channel.
// R09: Two-channel variant has one complementary output on channel zero.
// R10: Compact variants have one channel with one complementary output.
// R11: Complementary variants raise DMA requests; counter freezes in debug halt.
// R12: Advanced variant: four channels, three complementary outputs, DMA.
// R13: Every general variant works as PWM generator or plain timebase.
// R14: Basic variants have no channels, count up only, serve as timebases.
// R15: Reload at end of count signals update for IRQ, DMA and link.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/100ps
`include "pwt_defs.vh"

module pwt_timer #(
    parameter CH_NUM   = 4,   // Capture/compare channels, 0 for a basic timebase
    parameter COMP_NUM = 3,   // Channels with a complementary output
    parameter UPDOWN   = 1,   // Down and center counting allowed
    parameter ENC_EN   = 1,   // Quadrature encoder counting allowed
    parameter DMA_EN   = 1    // DMA request outputs active
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        dbg_halt,
    input  wire        link_trig_in,
    output reg         link_trig_out,
    input  wire        enc_a,
    input  wire        enc_b,
    input  wire [3:0]  cap_in,
    output reg  [3:0]  ch_out,
    output reg  [2:0]  ch_out_n,
    output reg  [4:0]  dma_req,
    output reg         irq
);
    localparam [3:0] CH_MASK   = (4'h1 << CH_NUM) - 4'h1;
    localparam [2:0] COMP_MASK = (3'h1 << COMP_NUM) - 3'h1;

    reg  [`PWT_CTRL_W-1:0] ctrl_reg;
    reg  [4:0]             status_reg;
    reg  [4:0]             imask_reg;
    reg  [4:0]             dmask_reg;
    reg  [15:0]            presc_reg;
    reg  [15:0]            reload_reg;
    reg  [7:0]             dt_reg;
    reg  [15:0]            ccmode_reg;
    reg  [6:0]             oen_reg;
    reg  [15:0]            cnt_reg;
    reg  [15:0]            psc_reg;
    reg                    down_reg;
    reg                    trig_q;
    reg                    enc_a_q;
    reg  [3:0]             cap_q;
    wire [15:0]            ccr_w [0:3];
    wire [3:0]             ref_w;
    wire [3:0]             cc_evt;

    // Bus access completes on the second access cycle; pready is registered
    wire acc     = psel & penable & pready;
    wire mapped  = (paddr[1:0] == 2'h0) &&
                   ((paddr <= `PWT_OUT_EN) ||
                    (paddr >= `PWT_CCR0 && paddr <= `PWT_CCR_LAST));
    wire wr      = acc & pwrite & mapped;                                   // Unmapped words drop writes

    // Counter controls
    wire [1:0] dir    = UPDOWN ? ctrl_reg[`PWT_CTRL_DIR_HI:`PWT_CTRL_DIR_LO]
                               : `PWT_DIR_UP;
    wire [1:0] slv    = ctrl_reg[`PWT_CTRL_SLV_HI:`PWT_CTRL_SLV_LO];
    wire       enc_on = (ENC_EN != 0) & ctrl_reg[`PWT_CTRL_ENC];
    wire       halted = dbg_halt & ctrl_reg[`PWT_CTRL_FRZ];                  // [R05] [R11]
    wire       trig_rise = link_trig_in & ~trig_q;
    wire       gate_ok   = (slv != `PWT_SLV_GATED) | link_trig_in;           // [R06]
    wire       run       = ctrl_reg[`PWT_CTRL_EN] & ~halted & gate_ok;
    wire       psc_adv   = (slv == `PWT_SLV_EXTCLK) ? trig_rise : 1'b1;     // [R06]
    wire       psc_wrap  = psc_adv & (psc_reg == presc_reg);                // [R01] [R08]
    wire       enc_chg   = enc_a ^ enc_a_q;
    wire       enc_up    = enc_a ^ enc_b;                                    // [R07]
    wire       step      = run & (enc_on ? enc_chg : psc_wrap);
    wire       center    = (dir == `PWT_DIR_CENTER);
    wire       going_dn  = enc_on ? ~enc_up : ((dir == `PWT_DIR_DOWN) | (center & down_reg));
    wire       at_end    = going_dn ? (cnt_reg == 16'h0000) : (cnt_reg == reload_reg);
    wire       trig_rst  = run & (slv == `PWT_SLV_RESET) & trig_rise;
    wire       upd_evt   = (step & at_end) | trig_rst;                       // [R15]
    wire       outs_off  = ~ctrl_reg[`PWT_CTRL_MOE] |
                           (dbg_halt & ctrl_reg[`PWT_CTRL_DOFF]);            // [R05]

    // Input history for edge detection
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_q  <= 1'b0;
            enc_a_q <= 1'b0;
            cap_q   <= 4'h0;
        end else begin
            trig_q  <= link_trig_in;
            enc_a_q <= enc_a;
            cap_q   <= cap_in;
        end
    end

    // Configuration registers; one-pulse mode drops the enable at the update
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg   <= {`PWT_CTRL_W{1'b0}};
            imask_reg  <= 5'h00;
            dmask_reg  <= 5'h00;
            presc_reg  <= 16'h0000;
            reload_reg <= `PWT_RELOAD_RST;
            dt_reg     <= 8'h00;
            ccmode_reg <= 16'h0000;
            oen_reg    <= 7'h00;
        end else begin
            if (wr && paddr == `PWT_CTRL)
                ctrl_reg <= pwdata[`PWT_CTRL_W-1:0];
            else if (upd_evt && ctrl_reg[`PWT_CTRL_OPM])
                ctrl_reg[`PWT_CTRL_EN] <= 1'b0;                              // [R02]
            if (wr && paddr == `PWT_IRQ_MASK)
                imask_reg <= pwdata[4:0];
            if (wr && paddr == `PWT_DMA_MASK)
                dmask_reg <= pwdata[4:0];
            if (wr && paddr == `PWT_PRESC)
                presc_reg <= pwdata[15:0];
            if (wr && paddr == `PWT_RELOAD)
                reload_reg <= pwdata[15:0];
            if (wr && paddr == `PWT_DEADTIME)
                dt_reg <= pwdata[7:0];
            if (wr && paddr == `PWT_CCMODE)
                ccmode_reg <= pwdata[15:0];
            if (wr && paddr == `PWT_OUT_EN)
                oen_reg <= pwdata[6:0];
        end
    end

    // Counter, prescaler and center-mode direction
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg  <= 16'h0000;
            psc_reg  <= 16'h0000;
            down_reg <= 1'b0;
        end else if (wr && paddr == `PWT_COUNT) begin
            cnt_reg <= pwdata[15:0];
            psc_reg <= 16'h0000;
        end else if (trig_rst) begin
            cnt_reg  <= 16'h0000;                                            // [R06]
            psc_reg  <= 16'h0000;
            down_reg <= 1'b0;
        end else begin
            if (run && psc_adv && !enc_on)
                psc_reg <= psc_wrap ? 16'h0000 : psc_reg + 16'h0001;
            if (step) begin
                if (at_end && center) begin
                    // Turn round at either end so both ends see the update
                    down_reg <= ~down_reg;
                    cnt_reg  <= going_dn ? cnt_reg + 16'h0001 : cnt_reg - 16'h0001;
                end else if (at_end)
                    cnt_reg <= going_dn ? reload_reg : 16'h0000;             // [R15] [R14]
                else
                    cnt_reg <= going_dn ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001; // [R01]
            end
        end
    end

    // Per-channel capture/compare logic; unbuilt channels stay idle
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_ch
            localparam integer CCR_OFS = 4 * i;
            reg  [15:0] ccr_reg;
            reg         tog_reg;
            wire [1:0]  mode  = ccmode_reg[4*i+1:4*i];
            wire        exist = CH_MASK[i];
            wire        match = exist && run && cnt_reg == ccr_reg;
            wire        capt  = exist && mode == `PWT_CC_CAPTURE &&
                                (ccmode_reg[4*i+3] ? (~cap_in[i] & cap_q[i])
                                                   : (cap_in[i] & ~cap_q[i]));
            assign ccr_w[i]  = ccr_reg;
            assign cc_evt[i] = capt | (match & (mode != `PWT_CC_CAPTURE));
            // Compare 0 never active, compare above reload always active
            assign ref_w[i]  = exist & ((mode == `PWT_CC_PWM) ? (cnt_reg < ccr_reg) // [R03]
                                                              : tog_reg);
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ccr_reg <= 16'h0000;
                    tog_reg <= 1'b0;
                end else begin
                    if (capt)
                        ccr_reg <= cnt_reg;                                  // [R02]
                    else if (wr && paddr == (`PWT_CCR0 + CCR_OFS[7:0]))
                        ccr_reg <= pwdata[15:0];
                    if (mode == `PWT_CC_TOGGLE && match && step)
                        tog_reg <= ~tog_reg;                                 // [R02]
                    else if (mode == `PWT_CC_FROZEN)
                        tog_reg <= 1'b0;
                end
            end
        end
    endgenerate

    // Dead-time pairs: each edge of the reference delays the rising side
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_dt
            reg [7:0] dt_cnt;
            reg       ref_q;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dt_cnt <= 8'h00;
                    ref_q  <= 1'b0;
                end else begin
                    ref_q <= ref_w[i];
                    if (ref_w[i] != ref_q)
                        dt_cnt <= 8'h00;                                     // [R04]
                    else if (dt_cnt != dt_reg)
                        dt_cnt <= dt_cnt + 8'h01;
                end
            end
            wire done = (ref_w[i] == ref_q) && (dt_cnt == dt_reg);
            wire comp = COMP_MASK[i] & oen_reg[4+i];
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ch_out[i]   <= 1'b0;
                    ch_out_n[i] <= 1'b0;
                end else begin
                    ch_out[i]   <= ~outs_off & oen_reg[i] & ref_w[i] & (~comp | done); // [R04] [R09] [R10] [R12]
                    ch_out_n[i] <= ~outs_off & comp & ~ref_w[i] & done;     // [R04]
                end
            end
        end
    endgenerate

    // Channel 3 never has a complementary partner
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ch_out[3] <= 1'b0;
        else
            ch_out[3] <= ~outs_off & oen_reg[3] & ref_w[3];                  // [R13]
    end

    // Sticky status: hardware set wins over a write-one clear in the same cycle
    wire [4:0] evt_w = {cc_evt & CH_MASK, upd_evt};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            status_reg <= 5'h00;
        else if (wr && paddr == `PWT_STATUS)
            status_reg <= (status_reg & ~pwdata[4:0]) | evt_w;
        else
            status_reg <= status_reg | evt_w;
    end

    // Interrupt level, DMA pulses and link output, all registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq           <= 1'b0;
            dma_req       <= 5'h00;
            link_trig_out <= 1'b0;
        end else begin
            irq           <= |(status_reg & imask_reg);
            dma_req       <= (DMA_EN != 0) ? (evt_w & dmask_reg) : 5'h00;    // [R07] [R11] [R12]
            link_trig_out <= upd_evt;                                        // [R06] [R15]
        end
    end

    // Read mux; the counter value reflects live state
    reg [31:0] rd_w;
    always @* begin
        rd_w = 32'h0000_0000;
        case (paddr)
            `PWT_CTRL:     rd_w = {21'h0, ctrl_reg};
            `PWT_STATUS:   rd_w = {27'h0, status_reg};
            `PWT_IRQ_MASK: rd_w = {27'h0, imask_reg};
            `PWT_DMA_MASK: rd_w = {27'h0, dmask_reg};
            `PWT_COUNT:    rd_w = {16'h0, cnt_reg};
            `PWT_PRESC:    rd_w = {16'h0, presc_reg};
            `PWT_RELOAD:   rd_w = {16'h0, reload_reg};
            `PWT_DEADTIME: rd_w = {24'h0, dt_reg};
            `PWT_CCMODE:   rd_w = {16'h0, ccmode_reg};
            `PWT_OUT_EN:   rd_w = {25'h0, oen_reg};
            8'h30:         rd_w = {16'h0, ccr_w[0]};
            8'h34:         rd_w = {16'h0, ccr_w[1]};
            8'h38:         rd_w = {16'h0, ccr_w[2]};
            8'h3c:         rd_w = {16'h0, ccr_w[3]};
            default:       rd_w = 32'h0000_0000;
        endcase
    end

    // APB handshake: one wait state, error on unmapped addresses
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel && penable && !pready && !pwrite)
                prdata <= mapped ? rd_w : 32'h0000_0000;
        end
    end
endmodule

// >>> test/pwt_timer_sva.sv
// Checker for the PWM timer: bus handshake, event pulses, pair outputs.
// Assumes it is bound to the timer top and sees only its ports.
`timescale 1ns/100ps
module pwt_timer_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        dbg_halt,
    input wire logic        link_trig_in,
    input wire logic        link_trig_out,
    input wire logic        enc_a,
    input wire logic        enc_b,
    input wire logic [3:0]  cap_in,
    input wire logic [3:0]  ch_out,
    input wire logic [2:0]  ch_out_n,
    input wire logic [4:0]  dma_req,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus answer: one wait state, one-cycle pulse, errors only with it
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_ready_wait: assert property ($rose(psel && penable) |=> pready)
        else $error("pready not one cycle after access start");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    a_err_misalign: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    a_err_in_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    // Reset must quieten every output but prdata and pslverr, so power stages stay off
    a_reset_quiet: assert property (disable iff (1'b0)
        !presetn && $past(!presetn) |-> !(|{pready, irq, link_trig_out, dma_req, ch_out, ch_out_n}))
        else $error("output active during reset");
    a_dma_link: assert property (dma_req[0] |-> link_trig_out)
        else $error("update request without link pulse");
    a_pair_excl: assert property (!(|(ch_out[2:0] & ch_out_n)))
        else $error("both sides of a pair active");
    // Status is only cleared by software, so irq falls two edges after a write
    a_irq_clear: assert property ($fell(irq) |-> $past(pready && pwrite, 2))
        else $error("irq fell without a register write");

    c_refused: cover property (pready && pslverr);
    c_irq: cover property ($rose(irq));
    c_pwm: cover property (ch_out[0] && !ch_out_n[0]);
endmodule

// >>> test/pwt_pins.sv
// Pin-side model: link trigger source, quadrature encoder, capture pins.
// Assumes the timer samples these as synchronous levels on pclk.
`timescale 1ns/100ps
module pwt_pins (
    input  wire logic  pclk,
    output logic       link_trig_in,
    output logic       enc_a,
    output logic       enc_b,
    output logic [3:0] cap_in
);
    // Idle levels from time zero
    initial begin
        link_trig_in = 1'b0;
        enc_a = 1'b0;
        enc_b = 1'b0;
        cap_in = 4'h0;
    end
    // One cycle high, one low, so every rise is seen
    task link_pulse(input int n);
        repeat (n) begin
            @(posedge pclk);
            link_trig_in <= 1'b1;
            @(posedge pclk);
            link_trig_in <= 1'b0;
        end
    endtask
    // The a line toggles; b is set so that a^b gives the direction
    task enc_step(input logic up);
        @(posedge pclk);
        enc_a <= ~enc_a;
        enc_b <= up ? enc_a : ~enc_a;
        repeat (2) @(posedge pclk);
    endtask
    // Held two cycles so a synchronous sampler cannot miss the edge
    task cap_pulse(input int ch);
        @(posedge pclk);
        cap_in[ch] <= 1'b1;
        repeat (2) @(posedge pclk);
        cap_in[ch] <= 1'b0;
        @(posedge pclk);
    endtask
endmodule

// >>> test/pwt_timer_bench.sv
// Bench for the PWM timer: APB tasks and one task per scenario.
// Assumes the pin model drives link, encoder and capture inputs.
`timescale 1ns/100ps
`include "pwt_defs.vh"
module pwt_timer_bench;
    localparam logic [31:0] EN = 32'h1, DN = 32'h2, CEN = 32'h4, FRZ = 32'h10;
    localparam logic [31:0] DOFF = 32'h20, MOE = 32'h40, EXT = 32'h300, ENC = 32'h400;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        dbg_halt, link_trig_in, link_trig_out, enc_a, enc_b, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, keep;
    logic [3:0]  cap_in, ch_out;
    logic [2:0]  ch_out_n;
    logic [4:0]  dma_req;
    int          errors = 0, checks_done = 0, cyc = 0;

    pwt_timer u_pwt_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dbg_halt(dbg_halt), .link_trig_in(link_trig_in),
        .link_trig_out(link_trig_out), .enc_a(enc_a), .enc_b(enc_b), .cap_in(cap_in),
        .ch_out(ch_out), .ch_out_n(ch_out_n), .dma_req(dma_req), .irq(irq));
    pwt_pins u_pins (.pclk(pclk), .link_trig_in(link_trig_in), .enc_a(enc_a),
        .enc_b(enc_b), .cap_in(cap_in));

    // 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            give_verdict();
        end
    end

    task chk(input string nm, input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task give_verdict();
        $display("errors %0d checks_done %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Request held until pready is sampled high; an idle edge between transfers
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask
    // Edges up to and including the next sampled update pulse
    task wait_upd(output int t);
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (link_trig_out !== 1'b1 && t < 100);
    endtask

    task t_regs();
        rdc("reload rst", `PWT_RELOAD, 32'h0000ffff);
        rdc("ctrl rst", `PWT_CTRL, 32'h0);
        wr(`PWT_DEADTIME, 32'h5);
        rdc("deadtime", `PWT_DEADTIME, 32'h5);
        apb(1'b0, 8'h2c, 32'h0);
        chk("unmapped err", {31'h0, er}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, 8'h06, 32'h1);
        chk("misaligned err", {31'h0, er}, 32'h1);
    endtask
    // Center mode period is left open, so only the update itself is checked
    task t_period(input logic [31:0] rl, ps, c, input int exp);
        int t;
        wr(`PWT_CTRL, 32'h0);
        wr(`PWT_RELOAD, rl);
        wr(`PWT_PRESC, ps);
        wr(`PWT_COUNT, 32'h0);
        wr(`PWT_CTRL, c);
        wait_upd(t);
        wait_upd(t);
        if (exp < 0)
            chk("center update", {31'h0, t < 20}, 32'h1);
        else
            chk("period", t, exp);
    endtask
    task t_irq();
        wr(`PWT_IRQ_MASK, 32'h1);
        wr(`PWT_DMA_MASK, 32'h1);
        t_period(32'h2, 32'h0, EN, 3);
        chk("dma update", {31'h0, dma_req[0]}, 32'h1);
        wr(`PWT_CTRL, 32'h0);
        apb(1'b0, `PWT_STATUS, 32'h0);
        chk("status update", rd & 32'h1, 32'h1);
        chk("irq set", {31'h0, irq}, 32'h1);
        wr(`PWT_IRQ_MASK, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(`PWT_IRQ_MASK, 32'h1);
        wr(`PWT_STATUS, 32'h1f);
        repeat (3) @(posedge pclk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
    endtask
    task hi_cnt(output int m, n);
        m = 0;
        n = 0;
        repeat (16) begin
            @(posedge pclk);
            m += ch_out[0];
            n += ch_out_n[0];
        end
    endtask
    task t_pwm();
        int m, n;
        t_period(32'h3, 32'h0, EN | MOE, 4);
        wr(`PWT_CCMODE, 32'h3);
        wr(`PWT_OUT_EN, 32'h11);
        wr(`PWT_DEADTIME, 32'h0);
        hi_cnt(m, n);
        chk("duty 0", m, 0);
        wr(`PWT_CCR0, 32'h4);
        repeat (8) @(posedge pclk);
        hi_cnt(m, n);
        chk("duty full", m, 16);
        wr(`PWT_CCR0, 32'h2);
        repeat (8) @(posedge pclk);
        hi_cnt(m, n);
        chk("main dead", m, 4);
        chk("comp dead", n, 4);
        wr(`PWT_CCR0, 32'h4);
        wr(`PWT_CTRL, EN | MOE | FRZ | DOFF);
        dbg_halt <= 1'b1;
        repeat (4) @(posedge pclk);
        hi_cnt(m, n);
        chk("debug off", m, 0);
        apb(1'b0, `PWT_COUNT, 32'h0);
        keep = rd;
        // Seven cycles apart, so a running period of four cannot mimic a hold
        repeat (3) @(posedge pclk);
        rdc("debug frozen", `PWT_COUNT, keep);
        dbg_halt <= 1'b0;
    endtask
    // One-pulse: the update after one count round drops the enable
    task t_opm();
        wr(`PWT_CTRL, 32'h0);
        wr(`PWT_RELOAD, 32'h3);
        wr(`PWT_COUNT, 32'h0);
        wr(`PWT_CTRL, EN | 32'h8);
        repeat (8) @(posedge pclk);
        rdc("one pulse stop", `PWT_CTRL, 32'h8);
        rdc("one pulse count", `PWT_COUNT, 32'h0);
    endtask
    task t_pins();
        wr(`PWT_CTRL, 32'h0);
        wr(`PWT_RELOAD, 32'hffff);
        wr(`PWT_COUNT, 32'h0);
        wr(`PWT_CTRL, EN | EXT);
        u_pins.link_pulse(5);
        rdc("link count", `PWT_COUNT, 32'h5);
        wr(`PWT_CTRL, EN | 32'h200);
        repeat (6) @(posedge pclk);
        rdc("gated hold", `PWT_COUNT, 32'h5);
        wr(`PWT_CTRL, 32'h0);
        wr(`PWT_COUNT, 32'h0);
        wr(`PWT_CTRL, EN | ENC);
        repeat (3) u_pins.enc_step(1'b1);
        u_pins.enc_step(1'b0);
        rdc("encoder count", `PWT_COUNT, 32'h2);
        wr(`PWT_CTRL, 32'h0);
        wr(`PWT_COUNT, 32'h0);
        wr(`PWT_CCMODE, 32'h10);
        wr(`PWT_CTRL, EN);
        wr(`PWT_STATUS, 32'h1f);
        u_pins.cap_pulse(1);
        apb(1'b0, `PWT_STATUS, 32'h0);
        chk("capture flag", rd & 32'h4, 32'h4);
    endtask

    // Reset for ten cycles, then the scenarios in turn
    initial begin
        {psel, penable, pwrite, dbg_halt} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_irq();
        t_period(32'h3, 32'h1, EN, 8);
        t_period(32'h3, 32'h0, EN | DN, 4);
        t_period(32'h3, 32'h0, EN | CEN, -1);
        t_opm();
        t_pwm();
        t_pins();
        give_verdict();
    end
endmodule

bind pwt_timer pwt_timer_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dbg_halt(dbg_halt), .link_trig_in(link_trig_in),
    .link_trig_out(link_trig_out), .enc_a(enc_a), .enc_b(enc_b), .cap_in(cap_in),
    .ch_out(ch_out), .ch_out_n(ch_out_n), .dma_req(dma_req), .irq(irq));
